//--- imupm_host_model.sv
// Host processor model: single register accesses on the request port.
// Assumes the device answers one cycle after it takes each strobe.
`timescale 1ns/1ps
module imupm_host_model #(
  parameter int WAIT_CYC = 5
) (
  input  wire logic                  clk_sys_in, // System clock
  input  wire imupm_pkg::imupm_rsp_t rsp_in,     // Device answer
  output imupm_pkg::imupm_req_t      req_out     // Request to device
);
  initial req_out = '0;

  // One access; answer is {refused, data}, all ones when none came
  task automatic access(input logic wr, input logic bst, input logic [7:0] adr,
                        input logic [7:0] wd, input bit asleep, output logic [8:0] ans);
    int n;
    ans = 9'h1FF;
    n = 0;
    @(posedge clk_sys_in);
    req_out <= '{wr: wr, rd: !wr, burst: bst, addr: adr, wdata: wd};
    @(posedge clk_sys_in);
    req_out <= '0;
    while (n < 4 && ans === 9'h1FF) begin
      @(negedge clk_sys_in);
      if (rsp_in.valid === 1'b1) ans = {rsp_in.refused, rsp_in.data};
      n++;
    end
    // pause after writes while asleep
    // Ends on a falling edge so callers look at settled outputs
    if (wr && asleep) repeat (WAIT_CYC + 2) @(negedge clk_sys_in);
  endtask : access
endmodule : imupm_host_model

//--- imupm_pkg.sv
// Package of constants and types for the inertial sensor power mode manager.
// Assumes a 100 MHz system clock; all register offsets and field layouts live here.
package imupm_pkg;

  // Clock and internal sample rates
  localparam int CLK_HZ       = 100_000_000;
  localparam int GYR_RATE_HZ  = 6400;
  localparam int ACC_RATE_HZ  = 1600;
  localparam int ACC_PER_GYR  = GYR_RATE_HZ / ACC_RATE_HZ;
  localparam int GYR_TICK_CYC = CLK_HZ / GYR_RATE_HZ;

  // Timing figures and their cycle counts (longest times round down)
  localparam int POWERUP_MS    = 10;
  localparam int GYR_START_MS  = 10;
  localparam int WR_WAIT_US    = 400;
  localparam int POWERUP_CYC   = CLK_HZ / 1000 * POWERUP_MS;
  localparam int GYR_START_CYC = CLK_HZ / 1000 * GYR_START_MS;
  localparam int WR_WAIT_CYC   = CLK_HZ / 1_000_000 * WR_WAIT_US;
  localparam int SETTLE_SMP    = 2;   // Analog settling, in accel sample periods

  // Register offsets
  localparam logic [7:0] ADDR_PMU_STATUS   = 8'h03;
  localparam logic [7:0] ADDR_FIFO_READOUT = 8'h24;
  localparam logic [7:0] ADDR_ACCEL_OUTPUT_CONFIG     = 8'h40;
  localparam logic [7:0] ADDR_GYRO_OUTPUT_CONFIG     = 8'h42;
  localparam logic [7:0] ADDR_FIFO_DEC     = 8'h45;
  localparam logic [7:0] ADDR_PMU_CMD      = 8'h7E;

  // Reset values
  localparam logic [7:0] ACCEL_OUTPUT_CONFIG_RST = 8'h13;
  localparam logic [7:0] GYRO_OUTPUT_CONFIG_RST = 8'h15;
  localparam logic [7:0] FIFO_DEC_RST = 8'h00;

  // Output config fields: rate exponent, filter bandwidth, undersample bit
  localparam int ODR_LSB = 0;
  localparam int ODR_W   = 4;
  localparam int BW_LSB  = 4;
  localparam int BW_W    = 3;
  localparam int US_BIT  = 7;

  // FIFO decimation fields
  localparam int FDEC_ACC_LSB = 0;
  localparam int FDEC_GYR_LSB = 4;
  localparam int FDEC_W       = 3;

  // Mode command and status fields
  localparam int CMD_MODE_LSB   = 0;
  localparam int CMD_SEL_BIT    = 2;
  localparam int ST_READY_BIT   = 0;
  localparam int ST_GSTART_BIT  = 1;
  localparam int ST_GMODE_LSB   = 2;
  localparam int ST_AMODE_LSB   = 4;
  localparam int ST_FLIMIT_BIT  = 6;
  localparam int ST_BUSY_BIT    = 7;

  typedef enum logic [1:0] {
    PM_SUSPEND   = 2'b00,
    PM_NORMAL    = 2'b01,
    PM_LOWPOWER  = 2'b10,
    PM_FASTSTART = 2'b11
  } imupm_mode_t;

  typedef enum logic [1:0] {
    ST_POWERUP = 2'b00,
    ST_RUN     = 2'b01,
    ST_GSTART  = 2'b10
  } imupm_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       burst;
    logic [7:0] addr;
    logic [7:0] wdata;
  } imupm_req_t;

  typedef struct packed {
    logic       valid;
    logic       refused;
    logic [7:0] data;
  } imupm_rsp_t;

  typedef struct packed {
    logic        acc_stb;
    logic        gyr_stb;
    logic [15:0] acc;
    logic [15:0] gyr;
  } imupm_frame_t;

endpackage : imupm_pkg

//--- imupm_power_mode_manager.sv
// Power mode manager and output rate front end of an inertial sensor.
// Assumes a register request port fed by the serial host interface and raw
// samples from the sensing elements on the same clock.
`timescale 1ns/1ps
module imupm_power_mode_manager #(
  parameter int GYR_TICK_CYC  = imupm_pkg::GYR_TICK_CYC,
  parameter int POWERUP_CYC   = imupm_pkg::POWERUP_CYC,
  parameter int GYR_START_CYC = imupm_pkg::GYR_START_CYC,
  parameter int WR_WAIT_CYC   = imupm_pkg::WR_WAIT_CYC,
  parameter int SETTLE_SMP    = imupm_pkg::SETTLE_SMP
) (
  input  wire logic                   clk_sys_in,       // System clock
  input  wire logic                   rst_in,           // Async reset, active high
  input  wire imupm_pkg::imupm_req_t  req_in,           // Register request
  input  wire logic [15:0]            acc_raw_in,       // Raw accel sample
  input  wire logic [15:0]            gyr_raw_in,       // Raw gyro sample
  output imupm_pkg::imupm_rsp_t       rsp_out,          // Register answer
  output imupm_pkg::imupm_frame_t     data_out,         // Output data registers
  output imupm_pkg::imupm_frame_t     fifo_out,         // Decimated frames
  output logic [23:0]                 sensor_time_out,  // Sensor time base
  output imupm_pkg::imupm_mode_t      acc_mode_out,     // Accel power mode
  output imupm_pkg::imupm_mode_t      gyr_mode_out,     // Gyro power mode
  output logic                        ready_out,        // Power-up complete
  output logic                        busy_out,         // Post-write wait
  output logic                        acc_sense_en_out, // Accel element on
  output logic                        gyr_sense_en_out, // Gyro sense on
  output logic                        gyr_drive_en_out  // Gyro drive on
);

  // Elaboration check
  if (GYR_TICK_CYC < 1 || POWERUP_CYC < 1 || GYR_START_CYC < 1 || WR_WAIT_CYC < 1
      || SETTLE_SMP < 0 || SETTLE_SMP > 1000) begin : g_bad_param
    $error("imupm: timing parameter out of range");
  end

  // Power of two for rate and averaging exponents
  function automatic logic [15:0] pow2(input logic [3:0] e);
    pow2 = 16'h0001 << e;
  endfunction : pow2

  // First order low pass, bandwidth set by shift
  function automatic logic [15:0] lpf(input logic signed [15:0] y,
                                      input logic signed [15:0] x,
                                      input logic [2:0]         bw);
    logic signed [16:0] diff;
    diff = 17'(x) - 17'(y);
    lpf = 16'(17'(y) + (diff >>> bw));
  endfunction : lpf

  localparam logic [16:0] SETTLE = 17'(SETTLE_SMP);

  imupm_pkg::imupm_state_t state_q;
  imupm_pkg::imupm_mode_t  acc_mode_q, gyr_mode_q, cmd_mode;
  imupm_pkg::imupm_rsp_t   rsp_q;
  imupm_pkg::imupm_frame_t data_q, fifo_q;
  logic [31:0] cnt_q, wait_q, gdiv_q;
  logic [23:0] sensor_time_q;
  logic [15:0] acc_ph_q, gyr_ph_q, acc_flt_q, gyr_flt_q, facc_q, fgyr_q;
  logic [15:0] acc_dec, acc_avg, gyr_dec, acc_nxt, gyr_nxt, facc_m, fgyr_m;
  logic [7:0]  accel_output_config_q, gyro_output_config_q, fdec_q, fifo_byte_q, rd_mux;
  logic [1:0]  gsub_q;
  logic        ready_q, busy_q, acc_sense_q, gyr_sense_q, gyr_drive_q;
  logic        gtick, atick, asleep, open, wr_ok, rd_ok, rd_hit, wr_hit;
  logic        cmd_ok, cmd_gyr, cmd_legal, acc_run, gyr_run;
  logic        acc_lp, accel_undersample_enable, acc_take, acc_duty, acc_wake, acc_last, gyr_last;

  // fixed sample ticks, accel derived from gyro so both stay aligned
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      gdiv_q <= 32'h00000000;
      gsub_q <= 2'h0;
    end else if (gdiv_q == 32'(GYR_TICK_CYC - 1)) begin
      gdiv_q <= 32'h00000000;
      gsub_q <= (gsub_q == 2'(imupm_pkg::ACC_PER_GYR - 1)) ? 2'h0 : gsub_q + 2'h1;
    end else begin
      gdiv_q <= gdiv_q + 32'h00000001;
    end
  end

  assign gtick = gdiv_q == 32'(GYR_TICK_CYC - 1);
  assign atick = gtick && gsub_q == 2'(imupm_pkg::ACC_PER_GYR - 1);

  // time base steps on the same edge that updates data; runs in every mode
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sensor_time_q <= 24'h000000;
    end else if (gtick) begin
      sensor_time_q <= sensor_time_q + 24'h000001;
    end
  end

  // Host access gating while gyro is suspended and accel is suspended or in low power
  always_comb begin
    asleep  = gyr_mode_q == imupm_pkg::PM_SUSPEND && acc_mode_q != imupm_pkg::PM_NORMAL;
    open    = state_q != imupm_pkg::ST_POWERUP && wait_q == 32'h00000000;
    wr_ok   = req_in.wr && !req_in.rd && open && !(asleep && req_in.burst);
    rd_ok   = req_in.rd && open && !(asleep && req_in.addr == imupm_pkg::ADDR_FIFO_READOUT);
    cmd_gyr = req_in.wdata[imupm_pkg::CMD_SEL_BIT];
    cmd_mode = imupm_pkg::imupm_mode_t'(req_in.wdata[imupm_pkg::CMD_MODE_LSB +: 2]);
    cmd_ok  = wr_ok && req_in.addr == imupm_pkg::ADDR_PMU_CMD && state_q == imupm_pkg::ST_RUN;
    // accel low power only beside gyro suspend; ignores rate setting
    if (cmd_gyr) begin
      cmd_legal = cmd_mode != imupm_pkg::PM_LOWPOWER
                  && (acc_mode_q != imupm_pkg::PM_LOWPOWER || cmd_mode == imupm_pkg::PM_SUSPEND);
    end else begin
      cmd_legal = cmd_mode != imupm_pkg::PM_FASTSTART
                  && (cmd_mode != imupm_pkg::PM_LOWPOWER || gyr_mode_q == imupm_pkg::PM_SUSPEND);
    end
  end

  // power-up then mode sequencing; one sensor per accepted command
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_q    <= imupm_pkg::ST_POWERUP;
      cnt_q      <= 32'h00000000;
      acc_mode_q <= imupm_pkg::PM_SUSPEND;
      gyr_mode_q <= imupm_pkg::PM_SUSPEND;
      ready_q    <= 1'b0;
    end else begin
      case (state_q)
        imupm_pkg::ST_POWERUP: begin
          if (cnt_q == 32'(POWERUP_CYC - 1)) begin
            state_q <= imupm_pkg::ST_RUN;
            cnt_q   <= 32'h00000000;
            ready_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 32'h00000001;
          end
        end
        imupm_pkg::ST_RUN: begin
          if (cmd_ok && cmd_legal) begin
            if (!cmd_gyr) begin
              acc_mode_q <= cmd_mode;
            end else if (cmd_mode == imupm_pkg::PM_NORMAL && gyr_mode_q != imupm_pkg::PM_NORMAL) begin
              state_q <= imupm_pkg::ST_GSTART;
            end else begin
              gyr_mode_q <= cmd_mode;
            end
          end
        end
        imupm_pkg::ST_GSTART: begin
          // gyro wake bounded by the start-up count
          if (cnt_q == 32'(GYR_START_CYC - 1)) begin
            state_q    <= imupm_pkg::ST_RUN;
            cnt_q      <= 32'h00000000;
            gyr_mode_q <= imupm_pkg::PM_NORMAL;
          end else begin
            cnt_q <= cnt_q + 32'h00000001;
          end
        end
        default: state_q <= imupm_pkg::ST_POWERUP;
      endcase
    end
  end

  // hold off the host after each write while asleep
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      wait_q <= 32'h00000000;
      busy_q <= 1'b0;
    end else if (wr_ok && asleep) begin
      wait_q <= 32'(WR_WAIT_CYC);
      busy_q <= 1'b1;
    end else if (wait_q != 32'h00000000) begin
      wait_q <= wait_q - 32'h00000001;
      busy_q <= wait_q != 32'h00000001;
    end
  end

  // Configuration registers
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      accel_output_config_q <= imupm_pkg::ACCEL_OUTPUT_CONFIG_RST;
      gyro_output_config_q <= imupm_pkg::GYRO_OUTPUT_CONFIG_RST;
      fdec_q     <= imupm_pkg::FIFO_DEC_RST;
    end else if (wr_ok) begin
      if (req_in.addr == imupm_pkg::ADDR_ACCEL_OUTPUT_CONFIG) begin
        accel_output_config_q <= req_in.wdata;
      end else if (req_in.addr == imupm_pkg::ADDR_GYRO_OUTPUT_CONFIG) begin
        gyro_output_config_q <= req_in.wdata;
      end else if (req_in.addr == imupm_pkg::ADDR_FIFO_DEC) begin
        fdec_q <= req_in.wdata;
      end
    end
  end

  // Read decode and write hit
  always_comb begin
    rd_hit = 1'b1;
    rd_mux = 8'h00;
    if (req_in.addr == imupm_pkg::ADDR_PMU_STATUS) begin
      rd_mux[imupm_pkg::ST_READY_BIT]       = ready_q;
      rd_mux[imupm_pkg::ST_GSTART_BIT]      = state_q == imupm_pkg::ST_GSTART;
      rd_mux[imupm_pkg::ST_GMODE_LSB +: 2]  = gyr_mode_q;
      rd_mux[imupm_pkg::ST_AMODE_LSB +: 2]  = acc_mode_q;
      rd_mux[imupm_pkg::ST_FLIMIT_BIT]      = acc_mode_q == imupm_pkg::PM_LOWPOWER;
      rd_mux[imupm_pkg::ST_BUSY_BIT]        = busy_q;
    end else if (req_in.addr == imupm_pkg::ADDR_FIFO_READOUT) begin
      rd_mux = fifo_byte_q;
    end else if (req_in.addr == imupm_pkg::ADDR_ACCEL_OUTPUT_CONFIG) begin
      rd_mux = accel_output_config_q;
    end else if (req_in.addr == imupm_pkg::ADDR_GYRO_OUTPUT_CONFIG) begin
      rd_mux = gyro_output_config_q;
    end else if (req_in.addr == imupm_pkg::ADDR_FIFO_DEC) begin
      rd_mux = fdec_q;
    end else begin
      rd_hit = 1'b0;
    end
    wr_hit = req_in.addr == imupm_pkg::ADDR_ACCEL_OUTPUT_CONFIG || req_in.addr == imupm_pkg::ADDR_GYRO_OUTPUT_CONFIG
             || req_in.addr == imupm_pkg::ADDR_FIFO_DEC || (cmd_ok && cmd_legal);
  end

  // Every request answered one cycle later, refused ones flagged
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rsp_q <= '0;
    end else begin
      rsp_q.valid   <= req_in.rd || req_in.wr;
      rsp_q.refused <= req_in.rd ? !(rd_ok && rd_hit) : (req_in.wr && !(wr_ok && wr_hit));
      rsp_q.data    <= (rd_ok && rd_hit) ? rd_mux : 8'h00;
    end
  end

  // Sampling schedule per sensor
  always_comb begin
    acc_dec  = pow2(accel_output_config_q[imupm_pkg::ODR_LSB +: imupm_pkg::ODR_W]);
    acc_avg  = pow2({1'b0, accel_output_config_q[imupm_pkg::BW_LSB +: imupm_pkg::BW_W]});
    gyr_dec  = pow2(gyro_output_config_q[imupm_pkg::ODR_LSB +: imupm_pkg::ODR_W]);
    acc_lp   = acc_mode_q == imupm_pkg::PM_LOWPOWER;
    acc_run  = acc_mode_q != imupm_pkg::PM_SUSPEND;
    // no gyro acquisition outside normal mode
    gyr_run  = gyr_mode_q == imupm_pkg::PM_NORMAL;
    // low power reuses the undersampled schedule
    accel_undersample_enable   = accel_output_config_q[imupm_pkg::US_BIT] || acc_lp;
    acc_take = !accel_undersample_enable || ({1'b0, acc_ph_q} + {1'b0, acc_avg} >= {1'b0, acc_dec});
    // gap too short to sleep keeps the element on
    acc_duty = acc_lp && ({1'b0, acc_dec} > {1'b0, acc_avg} + SETTLE);
    // awake for settling plus the averaged samples
    acc_wake = !acc_duty || ({1'b0, acc_ph_q} + {1'b0, acc_avg} + SETTLE >= {1'b0, acc_dec});
    acc_last = {1'b0, acc_ph_q} + 17'h00001 >= {1'b0, acc_dec};
    gyr_last = {1'b0, gyr_ph_q} + 17'h00001 >= {1'b0, gyr_dec};
    acc_nxt  = acc_take ? lpf(acc_flt_q, acc_raw_in, accel_output_config_q[imupm_pkg::BW_LSB +: imupm_pkg::BW_W])
                        : acc_flt_q;
    gyr_nxt  = lpf(gyr_flt_q, gyr_raw_in, gyro_output_config_q[imupm_pkg::BW_LSB +: imupm_pkg::BW_W]);
  end

  // filter and decimate to the output rate; holds data when stopped
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      acc_ph_q  <= 16'h0000;
      gyr_ph_q  <= 16'h0000;
      acc_flt_q <= 16'h0000;
      gyr_flt_q <= 16'h0000;
      data_q    <= '0;
    end else begin
      data_q.acc_stb <= 1'b0;
      data_q.gyr_stb <= 1'b0;
      if (atick && acc_run) begin
        acc_flt_q <= acc_nxt;
        acc_ph_q  <= acc_last ? 16'h0000 : acc_ph_q + 16'h0001;
        if (acc_last) begin
          data_q.acc     <= acc_nxt;
          data_q.acc_stb <= 1'b1;
        end
      end
      if (gtick && gyr_run) begin
        gyr_flt_q <= gyr_nxt;
        gyr_ph_q  <= gyr_last ? 16'h0000 : gyr_ph_q + 16'h0001;
        if (gyr_last) begin
          data_q.gyr     <= gyr_nxt;
          data_q.gyr_stb <= 1'b1;
        end
      end
    end
  end

  assign facc_m = pow2({1'b0, fdec_q[imupm_pkg::FDEC_ACC_LSB +: imupm_pkg::FDEC_W]}) - 16'h0001;
  assign fgyr_m = pow2({1'b0, fdec_q[imupm_pkg::FDEC_GYR_LSB +: imupm_pkg::FDEC_W]}) - 16'h0001;

  // pass one frame in each decimation group, drop the rest whole
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      facc_q      <= 16'h0000;
      fgyr_q      <= 16'h0000;
      fifo_q      <= '0;
      fifo_byte_q <= 8'h00;
    end else begin
      fifo_q.acc_stb <= data_q.acc_stb && facc_q == 16'h0000;
      fifo_q.gyr_stb <= data_q.gyr_stb && fgyr_q == 16'h0000;
      if (data_q.acc_stb) begin
        facc_q <= (facc_q + 16'h0001) & facc_m;
        if (facc_q == 16'h0000) begin
          fifo_q.acc  <= data_q.acc;
          fifo_byte_q <= data_q.acc[7:0];
        end
      end
      if (data_q.gyr_stb) begin
        fgyr_q <= (fgyr_q + 16'h0001) & fgyr_m;
        if (fgyr_q == 16'h0000) begin
          fifo_q.gyr <= data_q.gyr;
        end
      end
    end
  end

  // element enables follow modes, drive stays up in fast start
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      acc_sense_q <= 1'b0;
      gyr_sense_q <= 1'b0;
      gyr_drive_q <= 1'b0;
    end else begin
      acc_sense_q <= acc_run && acc_wake;
      gyr_sense_q <= gyr_run;
      gyr_drive_q <= gyr_run || gyr_mode_q == imupm_pkg::PM_FASTSTART;
    end
  end

  assign rsp_out          = rsp_q;
  assign data_out         = data_q;
  assign fifo_out         = fifo_q;
  assign sensor_time_out  = sensor_time_q;
  assign acc_mode_out     = acc_mode_q;
  assign gyr_mode_out     = gyr_mode_q;
  assign ready_out        = ready_q;
  assign busy_out         = busy_q;
  assign acc_sense_en_out = acc_sense_q;
  assign gyr_sense_en_out = gyr_sense_q;
  assign gyr_drive_en_out = gyr_drive_q;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  a_powerup_suspend:
    assert property ($rose(ready_q) |-> acc_mode_q == imupm_pkg::PM_SUSPEND
                     && gyr_mode_q == imupm_pkg::PM_SUSPEND) else $error("modes not suspend");
  a_powerup_bound:
    assert property (state_q == imupm_pkg::ST_POWERUP |-> cnt_q < 32'(POWERUP_CYC))
    else $error("power-up too long");
  a_suspend_no_data:
    assert property (acc_mode_q == imupm_pkg::PM_SUSPEND |=> !data_q.acc_stb)
    else $error("accel update in suspend");
  a_fast_keeps_data:
    assert property (gyr_mode_q == imupm_pkg::PM_FASTSTART && $past(gyr_mode_q) == imupm_pkg::PM_FASTSTART
                     |-> $stable(data_q.gyr) && !data_q.gyr_stb) else $error("gyro data changed");
  a_gyro_wake_bound:
    assert property (state_q == imupm_pkg::ST_GSTART |-> cnt_q < 32'(GYR_START_CYC))
    else $error("gyro wake too long");
  a_drive_in_fast:
    assert property (gyr_mode_q == imupm_pkg::PM_FASTSTART |=> gyr_drive_q && !gyr_sense_q)
    else $error("fast start enables wrong");
  a_lp_needs_gsusp:
    assert property (acc_mode_q == imupm_pkg::PM_LOWPOWER |-> gyr_mode_q == imupm_pkg::PM_SUSPEND)
    else $error("low power beside active gyro");
  a_single_move:
    assert property (!($changed(acc_mode_q) && $changed(gyr_mode_q))) else $error("diagonal move");
  a_time_align:
    assert property (data_q.acc_stb || data_q.gyr_stb |-> sensor_time_q != $past(sensor_time_q))
    else $error("update off time base");
  a_burst_refused:
    assert property (req_in.wr && !req_in.rd && req_in.burst && asleep |=> rsp_q.valid && rsp_q.refused)
    else $error("burst write taken");
  a_fifo_refused:
    assert property (req_in.rd && req_in.addr == imupm_pkg::ADDR_FIFO_READOUT && asleep
                     |=> rsp_q.refused && rsp_q.data == 8'h00) else $error("fifo read taken");
  a_lp_sense_off:
    assert property (acc_lp && !acc_wake |=> !acc_sense_q) else $error("element on while dozing");

endmodule : imupm_power_mode_manager

//--- imupm_power_mode_manager_tb.sv
// Self-checking bench for the power mode manager with a host model.
// Assumes short parameters; expectations come from integer models here.
`timescale 1ns/1ps
module imupm_power_mode_manager_tb;
  localparam int TK = 4, PU = 20, GS = 10, WW = 5;
  logic                    clk_sys_in, rst_in, rdy, bsy, ase, gse, gde;
  logic [15:0]             acc_raw, gyr_raw, g_old;
  logic [23:0]             st, t0;
  logic [8:0]              ans;
  imupm_pkg::imupm_req_t   req;
  imupm_pkg::imupm_rsp_t   rsp;
  imupm_pkg::imupm_frame_t dat, fif;
  imupm_pkg::imupm_mode_t  am, gm;
  int                      n_mismatch, check_count, seed, k, nd, nf;

  imupm_power_mode_manager #(.GYR_TICK_CYC(TK), .POWERUP_CYC(PU), .GYR_START_CYC(GS),
    .WR_WAIT_CYC(WW)) dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .req_in(req),
    .acc_raw_in(acc_raw), .gyr_raw_in(gyr_raw), .rsp_out(rsp), .data_out(dat),
    .fifo_out(fif), .sensor_time_out(st), .acc_mode_out(am), .gyr_mode_out(gm),
    .ready_out(rdy), .busy_out(bsy), .acc_sense_en_out(ase), .gyr_sense_en_out(gse),
    .gyr_drive_en_out(gde));
  imupm_host_model #(.WAIT_CYC(WW)) host (.clk_sys_in(clk_sys_in), .rsp_in(rsp),
    .req_out(req));

  // Clock of 10 ns period
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  // Bounded wait on ready (sel 0) or gyro strobe (sel 1); running out ends the run
  task automatic wait_for(input string nm, input int sel, input int lim);
    logic f;
    k = 0;
    f = 1'b0;
    do begin
      @(negedge clk_sys_in);
      k++;
      f = (sel == 0) ? rdy : dat.gyr_stb;
    end while (f !== 1'b1 && k < lim);
    if (f !== 1'b1) begin
      chk(nm, 0, 1);
      finish_test();
    end
  endtask : wait_for

  task automatic acc(input logic wr, input logic b, input logic [7:0] a,
                     input logic [7:0] d, input bit slp);
    host.access(wr, b, a, d, slp, ans);
  endtask : acc

  initial begin
    n_mismatch = 0;
    check_count = 0;
    seed = 32'h0EDDFDF5;
    rst_in = 1'b1;
    acc_raw = 16'h0000;
    gyr_raw = 16'h0000;
    repeat (5) @(posedge clk_sys_in);
    chk("modes", {am, gm, rdy}, 5'h00);
    rst_in <= 1'b0;
    acc_raw <= $random(seed);
    gyr_raw <= $random(seed);
    acc(0, 0, 8'h40, 8'h00, 1);
    chk("rd before ready", ans[8], 1);
    repeat (PU - 4) @(negedge clk_sys_in);
    chk("early ready", rdy, 0);
    wait_for("ready", 0, 4);
    // Reset values of the configuration registers
    for (int i = 0; i < 3; i++) begin
      acc(0, 0, i == 2 ? 8'h45 : 8'h40 + 8'(2 * i), 8'h00, 1);
      chk("conf rst", ans, i == 0 ? 9'h013 : i == 1 ? 9'h015 : 9'h000);
    end
    acc(0, 0, 8'h24, 8'h00, 1);
    chk("fifo rd asleep", ans[8], 1);
    acc(1, 1, 8'h40, 8'h12, 1);
    chk("burst wr asleep", ans[8], 1);
    g_old = 8'($random(seed));
    acc(1, 0, 8'h40, g_old[7:0], 0);
    chk("busy", bsy, 1);
    acc(1, 0, 8'h45, 8'h10, 1);
    chk("wr in wait", ans[8], 1);
    chk("busy end", bsy, 0);
    acc(0, 0, 8'h40, 8'h00, 1);
    chk("accel_output_config", ans, {1'b0, g_old[7:0]});
    $display("-- access test done");
    // Mode changes, one sensor per command
    acc(1, 0, 8'h7E, 8'h01, 1);
    chk("acc normal", {am, ase}, 3'b011);
    acc(1, 0, 8'h7E, 8'h05, 0);
    chk("gyr starting", gm, imupm_pkg::PM_SUSPEND);
    k = 0;
    while (gm !== imupm_pkg::PM_NORMAL && k < GS + 3) begin
      @(negedge clk_sys_in);
      k++;
    end
    chk("gyr start time", gm, imupm_pkg::PM_NORMAL);
    chk("gyr start bound", k <= GS, 1);
    acc(1, 0, 8'h7E, 8'h02, 0);
    chk("diag lp", {ans[8], am}, 3'b101);
    acc(1, 0, 8'h42, 8'h01, 0);
    acc(1, 0, 8'h45, 8'h10, 0);
    $display("-- mode test done");
    // Output rate, filter with no smoothing, time base step
    repeat (2) wait_for("gstb", 1, 200);
    for (int i = 0; i < 4; i++) begin
      t0 = st;
      @(negedge clk_sys_in);
      wait_for("gstb", 1, 200);
      chk("gyr data", dat.gyr, gyr_raw);
      chk("time step", st - t0, 2);
    end
    // one FIFO frame per two updates
    nd = 0;
    nf = 0;
    repeat (2) @(negedge clk_sys_in);
    for (int c = 0; c < 300 && nd < 8; c++) begin
      @(negedge clk_sys_in);
      nd += int'(dat.gyr_stb === 1'b1);
      nf += int'(fif.gyr_stb === 1'b1);
      if (fif.gyr_stb === 1'b1) chk("fifo data", fif.gyr, gyr_raw);
    end
    @(negedge clk_sys_in);
    nf += int'(fif.gyr_stb === 1'b1);
    chk("fifo frames", nf, 4);
    chk("data frames", nd, 8);
    $display("-- data test done");
    // Fast start-up keeps data and drive, stops sampling
    acc(1, 0, 8'h7E, 8'h07, 0);
    g_old = dat.gyr;
    @(posedge clk_sys_in);
    gyr_raw <= ~gyr_raw;
    // Sense enable drops one edge after the mode, so look a cycle later
    @(negedge clk_sys_in);
    chk("fast", {gm, gse, gde}, 4'b1101);
    k = 0;
    repeat (40) begin
      @(negedge clk_sys_in);
      k += int'(dat.gyr_stb === 1'b1);
    end
    chk("fast hold", {k[3:0], dat.gyr}, {4'h0, g_old});
    acc(1, 0, 8'h7E, 8'h05, 0);
    repeat (GS + 1) @(negedge clk_sys_in);
    chk("fast to normal", gm, imupm_pkg::PM_NORMAL);
    acc(1, 0, 8'h7E, 8'h04, 0);
    acc(1, 0, 8'h7E, 8'h02, 0);
    chk("acc lp", {gm, am}, 4'b0010);
    $display("-- power test done");
    finish_test();
  end
endmodule : imupm_power_mode_manager_tb
